// [dpc_params.svh]
// Register offsets, field positions, reset values and field encodings of the PLL setup registers.
// Included by the package and the design modules; holds definitions only.
`ifndef DPC_PARAMS_SVH
`define DPC_PARAMS_SVH

// Register offsets (byte addresses)
`define DPC_OFS_DIV_A       12'h0500
`define DPC_OFS_DIV_B       12'h0504
`define DPC_OFS_CTRL        12'h0508
`define DPC_ADDR_W          12

// Divider register A fields
`define DPC_FB_DIV_MSB      15
`define DPC_FB_DIV_LSB      6
`define DPC_FB_SHORT_W      7
`define DPC_REF_DIV_MSB     5
`define DPC_REF_DIV_LSB     0

// Divider register B fields
`define DPC_PLL_RESET_BIT   3
`define DPC_OUT_DIV_MSB     2
`define DPC_OUT_DIV_LSB     0
`define DPC_OUT_DIV_MAX     3'h5

// Control register fields
`define DPC_PD_BIT          15
`define DPC_FSE_BIT         14
`define DPC_ANA_SUP_BIT     13
`define DPC_CORE_SUP_BIT    12
`define DPC_BYPASS_BIT      11
`define DPC_LOCKCNT_MSB     10
`define DPC_LOCKCNT_LSB     7
`define DPC_LOCKWIN_MSB     6
`define DPC_LOCKWIN_LSB     4
`define DPC_FILT_MSB        3
`define DPC_FILT_LSB        0

// Lock counter exponent offset and filter range limit
`define DPC_LOCK_EXP_BASE   5
`define DPC_FILT_MAX        4'hb

// Reset values of the whole words
`define DPC_RST_DIV_A       32'h0000_0000
`define DPC_RST_DIV_B       32'h0000_000a
`define DPC_RST_CTRL        32'h0000_3f89

// Implemented bit masks; the upper bits are reserved
`define DPC_MASK_DIV_A      32'h0000_ffff
`define DPC_MASK_DIV_B      32'h0000_000f
`define DPC_MASK_CTRL       32'h0000_ffff

`endif

// [dpc_pkg.sv]
// Types shared by the PLL setup register block.
// Assumes dpc_params.svh is on the include path.
`include "dpc_params.svh"

package dpc_pkg;

    // Register selected by a bus address
    typedef enum logic [1:0] {
        DPC_SEL_NONE,
        DPC_SEL_DIV_A,
        DPC_SEL_DIV_B,
        DPC_SEL_CTRL
    } dpc_sel_t;

    // State of the field decoder
    typedef struct packed {
        logic [10:0] fb_div_eff_ff;
        logic [5:0]  out_div_ratio_ff;
        logic [4:0]  lock_exp_ff;
        logic        pll_held_ff;
        logic        pll_running_ff;
    } dpc_dec_state_t;

    // State of the register block
    typedef struct packed {
        logic [31:0]    div_a_ff;
        logic [31:0]    div_b_ff;
        logic [31:0]    ctrl_ff;
        logic [31:0]    rdata_ff;
    } dpc_reg_state_t;

endpackage : dpc_pkg

// [dpc_field_decode.sv]
// Field decoder: turns stored register fields into derived PLL status values.
// Assumes it sits in the same clock and reset domain as the register block.
`timescale 1ns/10ps
`include "dpc_params.svh"

module dpc_field_decode
    import dpc_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        clk_en,
    // Stored fields
    input  wire logic [9:0]  fb_div_field,
    input  wire logic        fb_range_select,
    input  wire logic        feedback_source_select,
    input  wire logic [2:0]  out_div_field,
    input  wire logic [3:0]  lock_delay_count,
    input  wire logic        pll_power_down,
    input  wire logic        pll_bypass,
    input  wire logic        pll_reset,
    // Derived values
    output logic [10:0] fb_div_ratio,
    output logic [5:0]  out_div_ratio,
    output logic [4:0]  lock_exponent,
    output logic        pll_held,
    output logic        pll_running
);

    dpc_dec_state_t st_ff;
    dpc_dec_state_t nxt_st;

    // Feedback ratio: the short range only applies with internal feedback
    function automatic logic [10:0] fb_ratio(input logic [9:0] code, input logic short_rng,
                                              input logic fse);
        logic [10:0] r;
        if (short_rng && fse) begin
            r = {4'h0, code[`DPC_FB_SHORT_W-1:0]} + 11'h001;
        end else begin
            r = {1'b0, code} + 11'h001;
        end
        return r;
    endfunction

    // Next state of the derived values
    always_comb begin
        nxt_st                  = st_ff;
        nxt_st.fb_div_eff_ff    = fb_ratio(fb_div_field, fb_range_select,
                                           feedback_source_select);
        nxt_st.out_div_ratio_ff = 6'h01 << out_div_field;
        nxt_st.lock_exp_ff      = {1'b0, lock_delay_count} + 5'(`DPC_LOCK_EXP_BASE);
        // Power-down, bypass or reset alike holds the PLL
        nxt_st.pll_held_ff      = pll_power_down | pll_bypass | pll_reset;
        nxt_st.pll_running_ff   = ~(pll_power_down | pll_bypass | pll_reset);
    end

    // Register the decoder state
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_ff <= '{fb_div_eff_ff: 11'h001, out_div_ratio_ff: 6'h04,
                       lock_exp_ff: 5'h14, pll_held_ff: 1'b1, pll_running_ff: 1'b0};
        end else if (clk_en) begin
            st_ff <= nxt_st;
        end
    end

    assign fb_div_ratio  = st_ff.fb_div_eff_ff;
    assign out_div_ratio = st_ff.out_div_ratio_ff;
    assign lock_exponent = st_ff.lock_exp_ff;
    assign pll_held      = st_ff.pll_held_ff;
    assign pll_running   = st_ff.pll_running_ff;

endmodule // dpc_field_decode

// [dpc_pll_cfg_regs.sv]
// What this block does
// - Feedback divisor bits 15:6 divide by value plus one, up to 1,024.
// - With range select and bit 14 both high, only the low seven bits count, up to 128; here range select is tied low, so all ten bits always count.
// - Reference divisor bits 5:0 divide by value plus one.
// - Divider B bit 3 holds the PLL in reset; resets to one.
// - Output divider bits 2:0 divide by two to the code; resets to two.
// - Power-down bit 15 stops the PLL, outputs low, overrides everything; resets low.
// - Bit 14 picks external pin (0) or internal feedback (1).
// - Bypass bit 11 powers core down, output follows reference; resets to one.
// - Lock counter bits 10:7 give two to the value plus five cycles.
// - Lock window bits 6:4 double from 500 to 64000 ppm.
// - Bits 13 and 12 pick analog and core supply; both reset high.
// - Every field drives its PLL input straight from the stored value.
// - Registers sit at 0x500, 0x504, 0x508, reset by bus reset.
//
// Holds the three PLL setup registers and their plain register port.
// Assumes a master that keeps strobes one cycle long and never waits.
//
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
`include "dpc_params.svh"

module dpc_pll_cfg_regs
    import dpc_pkg::*;
#(
    parameter int ADDR_W = `DPC_ADDR_W
)
(
    // Clock, reset, enable
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic              clk_en,
    // Register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic [31:0]            reg_rdata,
    // PLL dividers
    output logic [9:0]             fb_div_field,
    output logic                   fb_range_select,
    output logic [5:0]             ref_div_field,
    output logic [2:0]             out_div_field,
    output logic                   pll_reset,
    // PLL control
    output logic                   pll_power_down,
    output logic                   feedback_source_select,
    output logic                   analog_supply_sel,
    output logic                   core_supply_sel,
    output logic                   pll_bypass,
    output logic [3:0]             lock_delay_count,
    output logic [2:0]             lock_phase_window,
    output logic [3:0]             filter_range,
    // Derived status for the surroundings
    output logic [10:0]            fb_div_ratio,
    output logic [5:0]             out_div_ratio,
    output logic [4:0]             lock_exponent,
    output logic                   pll_held,
    output logic                   pll_running
);

    // Offsets need at least twelve address bits
    if (ADDR_W < `DPC_ADDR_W) begin : g_addr_chk
        $error("dpc_pll_cfg_regs: ADDR_W too narrow for the register offsets");
    end

    dpc_reg_state_t st_ff;
    dpc_reg_state_t nxt_st;
    logic           fse_ff;

    // Address decode shared by reads and writes
    function automatic dpc_sel_t decode(input logic [ADDR_W-1:0] a);
        dpc_sel_t s;
        s = DPC_SEL_NONE;
        if (a == ADDR_W'(`DPC_OFS_DIV_A)) begin
            s = DPC_SEL_DIV_A;
        end else if (a == ADDR_W'(`DPC_OFS_DIV_B)) begin
            s = DPC_SEL_DIV_B;
        end else if (a == ADDR_W'(`DPC_OFS_CTRL)) begin
            s = DPC_SEL_CTRL;
        end
        return s;
    endfunction

    // Next state: writes and read data capture
    always_comb begin
        dpc_sel_t sel;
        sel    = decode(reg_addr);
        nxt_st = st_ff;
        // Write lands on the edge that ends the strobe cycle
        if (reg_wr) begin
            unique case (sel)
                DPC_SEL_DIV_A: nxt_st.div_a_ff = reg_wdata & `DPC_MASK_DIV_A;
                DPC_SEL_DIV_B: nxt_st.div_b_ff = reg_wdata & `DPC_MASK_DIV_B;
                DPC_SEL_CTRL:  nxt_st.ctrl_ff  = reg_wdata & `DPC_MASK_CTRL;
                DPC_SEL_NONE:  nxt_st.div_a_ff = st_ff.div_a_ff;
            endcase
        end
        // Read data stands for exactly one enabled cycle; reserved and unmapped read zero
        nxt_st.rdata_ff = 32'h0000_0000;
        if (reg_rd) begin
            unique case (sel)
                DPC_SEL_DIV_A: nxt_st.rdata_ff = st_ff.div_a_ff;
                DPC_SEL_DIV_B: nxt_st.rdata_ff = st_ff.div_b_ff;
                DPC_SEL_CTRL:  nxt_st.rdata_ff = st_ff.ctrl_ff;
                DPC_SEL_NONE:  nxt_st.rdata_ff = 32'h0000_0000;
            endcase
        end
    end

    // Register the block state; bus reset restores the documented values
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_ff <= '{div_a_ff: `DPC_RST_DIV_A, div_b_ff: `DPC_RST_DIV_B,
                       ctrl_ff: `DPC_RST_CTRL, rdata_ff: 32'h0000_0000};
        end else if (clk_en) begin
            st_ff <= nxt_st;
        end
    end

    // Fields drive the PLL straight from the stored words, no extra logic
    assign fb_div_field           = st_ff.div_a_ff[`DPC_FB_DIV_MSB:`DPC_FB_DIV_LSB];
    assign ref_div_field          = st_ff.div_a_ff[`DPC_REF_DIV_MSB:`DPC_REF_DIV_LSB];
    assign pll_reset              = st_ff.div_b_ff[`DPC_PLL_RESET_BIT];
    assign out_div_field          = st_ff.div_b_ff[`DPC_OUT_DIV_MSB:`DPC_OUT_DIV_LSB];
    assign pll_power_down         = st_ff.ctrl_ff[`DPC_PD_BIT];
    assign feedback_source_select = fse_ff;
    assign analog_supply_sel      = st_ff.ctrl_ff[`DPC_ANA_SUP_BIT];
    assign core_supply_sel        = st_ff.ctrl_ff[`DPC_CORE_SUP_BIT];
    assign pll_bypass             = st_ff.ctrl_ff[`DPC_BYPASS_BIT];
    assign lock_delay_count       = st_ff.ctrl_ff[`DPC_LOCKCNT_MSB:`DPC_LOCKCNT_LSB];
    assign lock_phase_window      = st_ff.ctrl_ff[`DPC_LOCKWIN_MSB:`DPC_LOCKWIN_LSB];
    assign filter_range           = st_ff.ctrl_ff[`DPC_FILT_MSB:`DPC_FILT_LSB];
    assign reg_rdata              = st_ff.rdata_ff;
    assign fse_ff                 = st_ff.ctrl_ff[`DPC_FSE_BIT];

    // Short feedback range is a hardware strap level, not a register bit
    assign fb_range_select        = 1'b0;

    // Derived ratios, for status and test; one cycle behind the fields
    dpc_field_decode u_decode (
        .core_clk               (core_clk),
        .rst                    (rst),
        .clk_en                 (clk_en),
        .fb_div_field           (fb_div_field),
        .fb_range_select        (fb_range_select),
        .feedback_source_select (feedback_source_select),
        .out_div_field          (out_div_field),
        .lock_delay_count       (lock_delay_count),
        .pll_power_down         (pll_power_down),
        .pll_bypass             (pll_bypass),
        .pll_reset              (pll_reset),
        .fb_div_ratio           (fb_div_ratio),
        .out_div_ratio          (out_div_ratio),
        .lock_exponent          (lock_exponent),
        .pll_held               (pll_held),
        .pll_running            (pll_running)
    );

endmodule // dpc_pll_cfg_regs

// [dpc_pll_model.sv]
// Behavioural PLL macro driven by the setup fields of the register block.
// Assumes a free-running reference; divider ratios are not modelled.
`timescale 1ns/10ps
module dpc_pll_model (
    // Reference and control
    input  wire logic reference_clock_in,
    input  wire logic pll_power_down,
    input  wire logic pll_bypass,
    input  wire logic pll_reset,
    // Generated clock
    output logic      pll_output_clock
);
    // Power-down wins over bypass, bypass over reset; a held core gives no clock
    always_comb begin
        if (pll_power_down) pll_output_clock = 1'b0;
        else if (pll_bypass) pll_output_clock = reference_clock_in;
        else if (pll_reset) pll_output_clock = 1'b0;
        else pll_output_clock = reference_clock_in;
    end
endmodule // dpc_pll_model

// [dpc_pll_cfg_regs_assertions.sv]
// Checker for the PLL setup register block, bound onto its ports.
// Assumes one clock domain and the offsets of dpc_params.svh.
`timescale 1ns/10ps
`include "dpc_params.svh"
module dpc_pll_cfg_regs_assertions #(
    parameter int ADDR_W = `DPC_ADDR_W
) (
    // Clock, reset, enable
    input wire logic              core_clk,
    input wire logic              rst,
    input wire logic              clk_en,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0]       reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [31:0]       reg_rdata,
    // Fields
    input wire logic [9:0]        fb_div_field,
    input wire logic [5:0]        ref_div_field,
    input wire logic [2:0]        out_div_field,
    input wire logic              pll_reset,
    input wire logic              pll_power_down,
    input wire logic              feedback_source_select,
    input wire logic              analog_supply_sel,
    input wire logic              core_supply_sel,
    input wire logic              pll_bypass,
    input wire logic [3:0]        lock_delay_count,
    input wire logic [2:0]        lock_phase_window,
    input wire logic [3:0]        filter_range,
    // Derived
    input wire logic [10:0]       fb_div_ratio,
    input wire logic [5:0]        out_div_ratio,
    input wire logic [4:0]        lock_exponent,
    input wire logic              pll_held,
    input wire logic              pll_running
);
    default clocking dcb @(posedge core_clk); endclocking
    default disable iff (rst);
    // Fields seen as the words read back; reserved bits read zero
    wire logic [15:0] fa = {fb_div_field, ref_div_field};
    wire logic [3:0]  fbw = {pll_reset, out_div_field};
    wire logic [15:0] fc = {pll_power_down, feedback_source_select, analog_supply_sel,
        core_supply_sel, pll_bypass, lock_delay_count, lock_phase_window, filter_range};
    wire logic        rda = clk_en && reg_rd;
    wire logic        wra = clk_en && reg_wr;
    wire logic [31:0] view = reg_addr == `DPC_OFS_DIV_A ? {16'h0000, fa} :
        reg_addr == `DPC_OFS_DIV_B ? {28'h000_0000, fbw} :
        reg_addr == `DPC_OFS_CTRL ? {16'h0000, fc} : 32'h0000_0000;
    // Bus side
    property p_rd; rda |=> reg_rdata == $past(view); endproperty
    a_rd: assert property (p_rd) else $error("read data differ from fields");
    property p_idle; $past(clk_en) && !$past(rda) |-> reg_rdata == 32'h0000_0000; endproperty
    a_idle: assert property (p_idle) else $error("read data outside read slot");
    property p_wr_a; wra && reg_addr == `DPC_OFS_DIV_A |=> fa == $past(reg_wdata[15:0]); endproperty
    a_wr_a: assert property (p_wr_a) else $error("divider A write lost");
    property p_wr_b; wra && reg_addr == `DPC_OFS_DIV_B |=> fbw == $past(reg_wdata[3:0]); endproperty
    a_wr_b: assert property (p_wr_b) else $error("divider B write lost");
    property p_wr_c; wra && reg_addr == `DPC_OFS_CTRL |=> fc == $past(reg_wdata[15:0]); endproperty
    a_wr_c: assert property (p_wr_c) else $error("control write lost");
    property p_hold; !wra |=> $stable({fa, fbw, fc}); endproperty
    a_hold: assert property (p_hold) else $error("fields moved without write");
    // Derived values lag the fields by one cycle
    property p_fb; $past(clk_en) |-> fb_div_ratio == $past(fb_div_field) + 11'h001; endproperty
    a_fb: assert property (p_fb) else $error("feedback ratio wrong");
    property p_out;
        $past(clk_en) && $past(out_div_field) <= 3'h5 |->
            out_div_ratio == (6'h01 << $past(out_div_field));
    endproperty
    a_out: assert property (p_out) else $error("output ratio wrong");
    property p_lock; $past(clk_en) |-> lock_exponent == $past(lock_delay_count) + 5'h05; endproperty
    a_lock: assert property (p_lock) else $error("lock exponent wrong");
    property p_pd; clk_en && (pll_power_down || pll_bypass) |=> !pll_running; endproperty
    a_pd: assert property (p_pd) else $error("running while stopped");
    // Status flags follow the stop controls one cycle later, in both directions
    property p_run;
        $past(clk_en) |->
            pll_running == !($past(pll_power_down) || $past(pll_bypass) || $past(pll_reset));
    endproperty
    a_run: assert property (p_run) else $error("running flag wrong");
    property p_held;
        $past(clk_en) |->
            pll_held == ($past(pll_power_down) || $past(pll_bypass) || $past(pll_reset));
    endproperty
    a_held: assert property (p_held) else $error("held flag wrong");
    c_rd: cover property (rda && reg_addr == `DPC_OFS_CTRL);
    c_wr: cover property (wra && reg_addr == `DPC_OFS_DIV_B);
    c_pd: cover property (clk_en && pll_power_down);
    c_run: cover property (pll_running);
endmodule // dpc_pll_cfg_regs_assertions
bind dpc_pll_cfg_regs dpc_pll_cfg_regs_assertions #(.ADDR_W(ADDR_W)) u_chk (.*);

// [dpc_pll_cfg_regs_bench.sv]
// Bench for the PLL setup registers: bus driver, read-data monitor, PLL model.
// Assumes the checker is bound onto the design from its own file.
`timescale 1ns/10ps
module dpc_pll_cfg_regs_bench;
    logic core_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic [31:0] reg_wdata = 32'h0000_0000, d;
    logic [31:0] shd [3];
    logic [31:0] expq [$];
    integer seed = 32'h869d, err_count = 0, checks_done = 0, i, k;
    wire logic [31:0] reg_rdata;
    wire logic [10:0] fb_div_ratio;
    wire logic [9:0]  fb_div_field;
    wire logic [5:0]  ref_div_field, out_div_ratio;
    wire logic [4:0]  lock_exponent;
    wire logic [3:0]  lock_delay_count, filter_range;
    wire logic [2:0]  out_div_field, lock_phase_window;
    wire logic fb_range_select, pll_reset, pll_power_down, feedback_source_select, pll_out,
        analog_supply_sel, core_supply_sel, pll_bypass, pll_held, pll_running;
    dpc_pll_cfg_regs DUT (.*);
    dpc_pll_model u_pll (.reference_clock_in(core_clk), .pll_output_clock(pll_out), .*);
    initial forever #10 core_clk = ~core_clk;
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (e !== g) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One bus cycle; every input is assigned once per edge, so cycles chain
    task automatic op(input logic w, r, e, input logic [11:0] a, input logic [31:0] v);
        int n;
        n = (a - 12'h500) >> 2;
        @(posedge core_clk);
        {reg_wr, reg_rd, clk_en, reg_addr, reg_wdata} <= {w, r, e, a, v};
        if (a inside {12'h500, 12'h504, 12'h508}) begin
            if (w && e) shd[n] = v & (n == 1 ? 32'h0000_000f : 32'h0000_ffff);
            if (r) expq.push_back(shd[n]);
        end else if (r) expq.push_back(32'h0000_0000);
    endtask
    task automatic idle(input int c);
        repeat (c) op(1'b0, 1'b0, 1'b1, 12'h000, 32'h0000_0000);
    endtask
    task automatic chk_fields;
        @(negedge core_clk);
        cmp("div_a", shd[0], {16'h0000, fb_div_field, ref_div_field});
        cmp("div_b", shd[1], {28'h000_0000, pll_reset, out_div_field});
        cmp("ctrl", shd[2], {16'h0000, pll_power_down, feedback_source_select, analog_supply_sel,
            core_supply_sel, pll_bypass, lock_delay_count, lock_phase_window, filter_range});
    endtask
    // Reset words follow the documented field reset values
    task automatic do_reset;
        shd = '{32'h0000_0000, 32'h0000_000a, 32'h0000_3f89};
        rst <= 1'b1;
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
    endtask
    task automatic chk_reset;
        for (int j = 0; j < 4; j++) op(1'b0, 1'b1, 1'b1, 12'h500 + 12'(4 * j), 32'h0000_0000);
        idle(2);
        chk_fields;
        cmp("lock_exponent", 32'd20, {27'h0, lock_exponent});
        cmp("out_div_ratio", 32'd4, {26'h0, out_div_ratio});
        cmp("pll_held", 32'd1, {31'h0, pll_held});
        cmp("fb_range_select", 32'd0, {31'h0, fb_range_select});
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Read data stand one cycle after the strobe is taken; compare there
    always @(posedge core_clk) begin
        if (rd_d) cmp("reg_rdata", expq.pop_front(), reg_rdata);
        rd_d <= reg_rd && clk_en;
    end
    // A hang far beyond the two hundred or so cycles of the run counts as a mismatch
    initial begin
        #400000;
        err_count++;
        conclude;
    end
    initial begin
        do_reset;
        chk_reset;
        $display("end of test reset values");
        for (i = 0; i < 40; i++) begin
            k = {$random(seed)} % 3;
            d = $random(seed) & 32'h0000_ffff;
            if (k == 2) d = d | 32'h0000_0800;
            if (k == 1 && d[2:0] == 3'h0) d = d | 32'h0000_0008;
            op(1'b1, 1'b0, 1'b1, 12'h500 + 12'(4 * k), d);
            op(1'b0, 1'b1, 1'b1, 12'h500 + 12'(4 * k), 32'h0000_0000);
        end
        idle(2);
        chk_fields;
        $display("end of test random words");
        // Reserved bits and an unmapped word must drop writes of all ones
        for (i = 0; i < 8; i++) op(i < 4, i >= 4, 1'b1, 12'h500 + 12'(4 * (i % 4)), 32'hffff_ffff);
        idle(2);
        cmp("fb_div_ratio", 32'd1024, {21'h0, fb_div_ratio});
        cmp("pll_running", 32'd0, {31'h0, pll_running});
        cmp("pll_held", 32'd1, {31'h0, pll_held});
        cmp("pll_out", 32'd0, {31'h0, pll_out});
        $display("end of test reserved bits");
        for (i = 0; i < 16; i++) begin
            op(1'b1, 1'b0, 1'b1, 12'h508, 32'h0000_3800 | (i << 7) | ((i % 8) << 4) | (i % 12));
            if (i < 6) op(1'b1, 1'b0, 1'b1, 12'h504, 32'h0000_0008 | i);
            idle(2);
            chk_fields;
            cmp("lock_exponent", 32'(i + 5), {27'h0, lock_exponent});
            if (i < 6) cmp("out_div_ratio", 32'(1 << i), {26'h0, out_div_ratio});
        end
        $display("end of test field codes");
        // Setup complete: release reset under bypass first, then drop bypass
        op(1'b1, 1'b0, 1'b1, 12'h504, 32'h0000_0002);
        op(1'b1, 1'b0, 1'b1, 12'h508, 32'h0000_3789);
        idle(2);
        chk_fields;
        cmp("pll_running", 32'd1, {31'h0, pll_running});
        cmp("pll_held", 32'd0, {31'h0, pll_held});
        // Look well after the edge so the model's output has settled
        @(posedge core_clk);
        #2;
        cmp("pll_out", 32'd1, {31'h0, pll_out});
        $display("end of test running core");
        op(1'b1, 1'b0, 1'b0, 12'h508, 32'h0000_0000);
        idle(2);
        chk_fields;
        op(1'b1, 1'b0, 1'b1, 12'h504, 32'h0000_0003);
        idle(1);
        do_reset;
        chk_reset;
        $display("end of test enable and reset");
        conclude;
    end
endmodule // dpc_pll_cfg_regs_bench
